// file: prcg_map.svh
// register map, field positions and reset values of the peripheral reset and clock gating block
`ifndef PRCG_MAP_SVH
`define PRCG_MAP_SVH

// bus geometry
`define PRCG_DATA_W        32
`define PRCG_ADDR_LSB_W    8
`define PRCG_NUM_GATES     26
`define PRCG_HSIZE_WORD    3'h2
`define PRCG_HTRANS_NONSEQ 2'h2
`define PRCG_HTRANS_SEQ    2'h3
`define PRCG_ZERO_WORD     32'h0000_0000

// register byte offsets
`define PRCG_OFS_HS_RST    8'h0c
`define PRCG_OFS_LS_RST    8'h10
`define PRCG_OFS_SYS_EN    8'h14
`define PRCG_OFS_HS_EN     8'h18
`define PRCG_OFS_LS_EN     8'h1c

// reset values
`define PRCG_RST_HS_RST    32'h0000_0000
`define PRCG_RST_LS_RST    32'h0000_0000
`define PRCG_RST_SYS_EN    32'h0000_0014
`define PRCG_RST_HS_EN     32'h0000_0000
`define PRCG_RST_LS_EN     32'h0000_0000

// implemented bits; everything else is reserved, reads zero
`define PRCG_MASK_HS_RST   32'h0007_5a01
`define PRCG_MASK_LS_RST   32'h1062_4912
`define PRCG_MASK_SYS_EN   32'h004e_0055
`define PRCG_MASK_HS_EN    32'h0047_5a01
`define PRCG_MASK_LS_EN    32'h1062_4912

// high-speed bus reset and enable fields (same positions in both; debug support clock bit is in the enable register only)
`define PRCG_DEBUG_SUPPORT_CLOCK_ON      22
`define PRCG_TMR_SIXTEEN_BIT             18
`define PRCG_TMR_FIFTEEN_BIT             17
`define PRCG_TMR_FOURTEEN_BIT            16
`define PRCG_SERIAL_PORT_A_BIT           14
`define PRCG_SYNC_SERIAL_A_BIT           12
`define PRCG_ADVANCED_TMR_BIT            11
`define PRCG_CONVERTER_BIT               9
`define PRCG_SYSCFG_COMPARATOR_BIT       0

// low-speed bus reset and enable fields (same positions in both)
`define PRCG_POWER_UNIT_BIT              28
`define PRCG_TWO_WIRE_B_BIT              22
`define PRCG_TWO_WIRE_A_BIT              21
`define PRCG_SERIAL_PORT_B_BIT           17
`define PRCG_SYNC_SERIAL_B_BIT           14
`define PRCG_WINDOW_DOG_BIT              11
`define PRCG_TMR_THIRTEEN_BIT            8
`define PRCG_TMR_FIVE_BIT                4
`define PRCG_TMR_TWO_BIT                 1

// system bus enable fields
`define PRCG_PORT_F_CLOCK_ON             22
`define PRCG_PORT_C_CLOCK_ON             19
`define PRCG_PORT_B_CLOCK_ON             18
`define PRCG_PORT_A_CLOCK_ON             17
`define PRCG_CHECKSUM_CLOCK_ON           6
`define PRCG_FLASH_CTRL_SLEEP_CLOCK_ON   4
`define PRCG_STATIC_MEM_SLEEP_CLOCK_ON   2
`define PRCG_MEM_TRANSFER_CLOCK_ON       0

`endif

// file: prcg_pkg.sv
// types shared by the peripheral reset and clock gating block
package prcg_pkg;
  `include "prcg_map.svh"

  typedef logic [`PRCG_DATA_W-1:0]     prcg_word_t;
  typedef logic [`PRCG_ADDR_LSB_W-1:0] prcg_ofs_t;

  // the five software registers
  typedef struct packed {
    prcg_word_t hsRst;
    prcg_word_t lsRst;
    prcg_word_t sysEn;
    prcg_word_t hsEn;
    prcg_word_t lsEn;
  } prcg_regs_t;

  // register and bus state of the top module; the reset release chain is kept apart
  typedef struct packed {
    prcg_regs_t regs;
    logic       wrPend;
    prcg_ofs_t  wrOfs;
    prcg_word_t rdData;
  } prcg_state_t;

  // reset release chain
  typedef struct packed {
    logic stage1;
    logic stage2;
  } prcg_rsync_t;

  // state of one clock gate
  typedef struct packed {
    logic enHeld;
  } prcg_gate_t;
endpackage

// file: prcg_clk_gate.sv
// glitch-free clock gate for one peripheral clock
`timescale 1ns/10ps
module prcg_clk_gate (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstN,
  // enable level and gated clock
  input  wire logic enable,
  output wire logic gatedClk
);
  import prcg_pkg::*;

  prcg_gate_t st_ff;
  prcg_gate_t nxt_st;

  // next enable is just the request
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.enHeld = enable;
  end

  // captured on the falling edge, so apart from rstN falling it only changes while the clock is low
  always_ff @(negedge clock or negedge rstN) begin
    if (!rstN) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // held level moves in the high phase only when rstN falls, which can cut a pulse short
  assign gatedClk = clock & st_ff.enHeld; // [R24]
endmodule

// file: prcg_top.sv
// peripheral reset and clock gating control with an ahb-lite register slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps
`include "prcg_map.svh"

// Summary of operation
// (R1) High-speed reset bits 18,17,16 hold timers sixteen, fifteen, fourteen in reset.
// (R2) High-speed reset bits 14,12,11,9 reset serial A, sync serial A, advanced timer, converter.
// (R3) High-speed reset bit 0 resets system configuration and comparator together.
// (R4) Low-speed reset bit 28 resets the power control unit.
// (R5) Low-speed reset bits 22,21,17,14 reset two-wire B, A, serial B, sync serial B.
// (R6) Low-speed reset bit 11 holds the windowed watchdog in reset.
// (R7) Low-speed reset bits 8,4,1 reset timers thirteen, five and two.
// (R8) Low-speed reset register sits at 0x10 and clears to zero.
// (R9) System enable bits 22,19,18,17 gate port F, C, B, A clocks.
// (R10) System enable bit 6 gates the checksum unit clock.
// (R11) System enable bit 0 gates the memory transfer controller clock.
// (R12) System enable bit 4 keeps flash controller clock running in sleep.
// (R13) System enable bit 2 keeps static memory clock running in sleep.
// (R14) System enable register at 0x14 resets to 0x0000_0014.
// (R15) High-speed enable bit 22 gates the debug support clock.
// (R16) High-speed enable register at 0x18, reset zero, bits 18..16 gate three timers.
// (R17) High-speed enable bits 14,12,11,9 gate serial A, sync A, timer, converter.
// (R18) High-speed enable bit 0 gates system configuration and comparator clock.
// (R19) Low-speed enable register at 0x1c, reset zero, bit 28 gates power unit.
// (R20) Low-speed enable bits 22,21,17,14 gate two-wire B, A, serial B, sync B.
// (R21) Low-speed enable bits 11,8,4,1 gate watchdog and timers thirteen, five, two.
// (R22) High-speed reset register sits at 0x0c, resets zero, bits 31..19 reserved.
// (R23) Bits change only on software writes; reserved bits read zero, ignore writes.
// (R24) Every clock enable gates its clock glitch-free, no truncated pulse; a falling rstN clears the gates at once and can cut a pulse.
module prcg_top (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                arst_n,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire prcg_pkg::prcg_word_t hwdata,
  input  wire logic                hready,
  output wire logic                hreadyout,
  output wire logic                hresp,
  output wire prcg_pkg::prcg_word_t hrdata,
  // power mode
  input  wire logic                sleepMode,
  // high-speed bus peripheral resets, active high
  output wire logic                tmrSixteenReset,
  output wire logic                tmrFifteenReset,
  output wire logic                tmrFourteenReset,
  output wire logic                serialPortAReset,
  output wire logic                syncSerialAReset,
  output wire logic                advancedTmrReset,
  output wire logic                converterReset,
  output wire logic                syscfgComparatorReset,
  // low-speed bus peripheral resets, active high
  output wire logic                powerUnitReset,
  output wire logic                twoWireBReset,
  output wire logic                twoWireAReset,
  output wire logic                serialPortBReset,
  output wire logic                syncSerialBReset,
  output wire logic                windowDogReset,
  output wire logic                tmrThirteenReset,
  output wire logic                tmrFiveReset,
  output wire logic                tmrTwoReset,
  // system bus gated clocks
  output wire logic                portFClk,
  output wire logic                portCClk,
  output wire logic                portBClk,
  output wire logic                portAClk,
  output wire logic                checksumClk,
  output wire logic                memTransferClk,
  output wire logic                flashCtrlClk,
  output wire logic                staticMemClk,
  // high-speed bus gated clocks
  output wire logic                debugSupportClk,
  output wire logic                tmrSixteenClk,
  output wire logic                tmrFifteenClk,
  output wire logic                tmrFourteenClk,
  output wire logic                serialPortAClk,
  output wire logic                syncSerialAClk,
  output wire logic                advancedTmrClk,
  output wire logic                converterClk,
  output wire logic                syscfgComparatorClk,
  // low-speed bus gated clocks
  output wire logic                powerUnitClk,
  output wire logic                twoWireBClk,
  output wire logic                twoWireAClk,
  output wire logic                serialPortBClk,
  output wire logic                syncSerialBClk,
  output wire logic                windowDogClk,
  output wire logic                tmrThirteenClk,
  output wire logic                tmrFiveClk,
  output wire logic                tmrTwoClk
);
  import prcg_pkg::*;

  prcg_rsync_t                 rsync_ff;
  prcg_rsync_t                 nxt_rsync;
  prcg_state_t                 st_ff;
  prcg_state_t                 nxt_st;
  logic                        rstN;
  logic                        takeXfer;
  logic                        takeWrite;
  logic                        takeRead;
  prcg_ofs_t                   addrOfs;
  logic [`PRCG_NUM_GATES-1:0]  gateEn;
  logic [`PRCG_NUM_GATES-1:0]  gatedVec;
  logic                        flashRun;
  logic                        staticRun;

  // register read mux; unmapped offsets and reserved bits give zero
  function automatic prcg_word_t readReg(input prcg_ofs_t ofs, input prcg_regs_t r);
    prcg_word_t val;
    val = `PRCG_ZERO_WORD;
    unique case (ofs)
      `PRCG_OFS_HS_RST: val = r.hsRst & `PRCG_MASK_HS_RST; // [R22] [R23]
      `PRCG_OFS_LS_RST: val = r.lsRst & `PRCG_MASK_LS_RST; // [R8] [R23]
      `PRCG_OFS_SYS_EN: val = r.sysEn & `PRCG_MASK_SYS_EN; // [R14] [R23]
      `PRCG_OFS_HS_EN:  val = r.hsEn & `PRCG_MASK_HS_EN;   // [R16] [R23]
      `PRCG_OFS_LS_EN:  val = r.lsEn & `PRCG_MASK_LS_EN;   // [R19] [R23]
      default:          val = `PRCG_ZERO_WORD;
    endcase
    return val;
  endfunction

  // reset release chain: stage1 feeds only stage2
  always_comb begin
    nxt_rsync        = rsync_ff;
    nxt_rsync.stage1 = 1'b1;
    nxt_rsync.stage2 = rsync_ff.stage1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rsync_ff <= '0;
    end else begin
      rsync_ff <= nxt_rsync;
    end
  end

  assign rstN = rsync_ff.stage2;

  // address phase qualification; only whole-word writes change a register
  assign takeXfer  = hsel & hready & ((htrans == `PRCG_HTRANS_NONSEQ) |
                                      (htrans == `PRCG_HTRANS_SEQ));
  assign takeWrite = takeXfer & hwrite & (hsize == `PRCG_HSIZE_WORD);
  assign takeRead  = takeXfer & ~hwrite;
  assign addrOfs   = haddr[`PRCG_ADDR_LSB_W-1:0];

  // next state: finish a pending write, then register the new address phase
  always_comb begin
    nxt_st = st_ff;
    // registers move only on a software write, never by hardware
    if (st_ff.wrPend) begin // [R23]
      unique case (st_ff.wrOfs)
        `PRCG_OFS_HS_RST: nxt_st.regs.hsRst = hwdata & `PRCG_MASK_HS_RST; // [R22] [R23]
        `PRCG_OFS_LS_RST: nxt_st.regs.lsRst = hwdata & `PRCG_MASK_LS_RST; // [R8] [R23]
        `PRCG_OFS_SYS_EN: nxt_st.regs.sysEn = hwdata & `PRCG_MASK_SYS_EN; // [R14] [R23]
        `PRCG_OFS_HS_EN:  nxt_st.regs.hsEn  = hwdata & `PRCG_MASK_HS_EN;  // [R16] [R23]
        `PRCG_OFS_LS_EN:  nxt_st.regs.lsEn  = hwdata & `PRCG_MASK_LS_EN;  // [R19] [R23]
        default: nxt_st.regs = st_ff.regs; // unmapped write is dropped, still okay
      endcase
    end
    nxt_st.wrPend = takeWrite;
    nxt_st.wrOfs  = takeWrite ? addrOfs : st_ff.wrOfs;
    // reading the post-write image forwards a write just ahead of the read
    if (takeRead) begin
      nxt_st.rdData = readReg(addrOfs, nxt_st.regs);
    end
  end

  // all registers clear to their documented values on system reset
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      st_ff.regs.hsRst <= `PRCG_RST_HS_RST; // [R22]
      st_ff.regs.lsRst <= `PRCG_RST_LS_RST; // [R8]
      st_ff.regs.sysEn <= `PRCG_RST_SYS_EN; // [R14]
      st_ff.regs.hsEn  <= `PRCG_RST_HS_EN;  // [R16]
      st_ff.regs.lsEn  <= `PRCG_RST_LS_EN;  // [R19]
      st_ff.wrPend     <= 1'b0;
      st_ff.wrOfs      <= '0;
      st_ff.rdData     <= `PRCG_ZERO_WORD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_ff.rdData;

  // high-speed bus resets, held while the bit stays one
  assign tmrSixteenReset       = st_ff.regs.hsRst[`PRCG_TMR_SIXTEEN_BIT];  // [R1]
  assign tmrFifteenReset       = st_ff.regs.hsRst[`PRCG_TMR_FIFTEEN_BIT];  // [R1]
  assign tmrFourteenReset      = st_ff.regs.hsRst[`PRCG_TMR_FOURTEEN_BIT]; // [R1]
  assign serialPortAReset      = st_ff.regs.hsRst[`PRCG_SERIAL_PORT_A_BIT]; // [R2]
  assign syncSerialAReset      = st_ff.regs.hsRst[`PRCG_SYNC_SERIAL_A_BIT]; // [R2]
  assign advancedTmrReset      = st_ff.regs.hsRst[`PRCG_ADVANCED_TMR_BIT];  // [R2]
  assign converterReset        = st_ff.regs.hsRst[`PRCG_CONVERTER_BIT];     // [R2]
  // one bit resets both the configuration logic and the comparator
  assign syscfgComparatorReset = st_ff.regs.hsRst[`PRCG_SYSCFG_COMPARATOR_BIT]; // [R3]

  // low-speed bus resets
  assign powerUnitReset   = st_ff.regs.lsRst[`PRCG_POWER_UNIT_BIT];    // [R4]
  assign twoWireBReset    = st_ff.regs.lsRst[`PRCG_TWO_WIRE_B_BIT];    // [R5]
  assign twoWireAReset    = st_ff.regs.lsRst[`PRCG_TWO_WIRE_A_BIT];    // [R5]
  assign serialPortBReset = st_ff.regs.lsRst[`PRCG_SERIAL_PORT_B_BIT]; // [R5]
  assign syncSerialBReset = st_ff.regs.lsRst[`PRCG_SYNC_SERIAL_B_BIT]; // [R5]
  assign windowDogReset   = st_ff.regs.lsRst[`PRCG_WINDOW_DOG_BIT];    // [R6]
  assign tmrThirteenReset = st_ff.regs.lsRst[`PRCG_TMR_THIRTEEN_BIT];  // [R7]
  assign tmrFiveReset     = st_ff.regs.lsRst[`PRCG_TMR_FIVE_BIT];      // [R7]
  assign tmrTwoReset      = st_ff.regs.lsRst[`PRCG_TMR_TWO_BIT];       // [R7]

  // memory clocks always run outside sleep; in sleep their bit decides
  assign flashRun  = ~sleepMode | st_ff.regs.sysEn[`PRCG_FLASH_CTRL_SLEEP_CLOCK_ON];  // [R12]
  assign staticRun = ~sleepMode | st_ff.regs.sysEn[`PRCG_STATIC_MEM_SLEEP_CLOCK_ON]; // [R13]

  // gate enables, ordered as the gated clock outputs below
  assign gateEn = {
    st_ff.regs.sysEn[`PRCG_PORT_F_CLOCK_ON],        // [R9]
    st_ff.regs.sysEn[`PRCG_PORT_C_CLOCK_ON],        // [R9]
    st_ff.regs.sysEn[`PRCG_PORT_B_CLOCK_ON],        // [R9]
    st_ff.regs.sysEn[`PRCG_PORT_A_CLOCK_ON],        // [R9]
    st_ff.regs.sysEn[`PRCG_CHECKSUM_CLOCK_ON],      // [R10]
    st_ff.regs.sysEn[`PRCG_MEM_TRANSFER_CLOCK_ON],  // [R11]
    flashRun,
    staticRun,
    st_ff.regs.hsEn[`PRCG_DEBUG_SUPPORT_CLOCK_ON],  // [R15]
    st_ff.regs.hsEn[`PRCG_TMR_SIXTEEN_BIT],         // [R16]
    st_ff.regs.hsEn[`PRCG_TMR_FIFTEEN_BIT],         // [R16]
    st_ff.regs.hsEn[`PRCG_TMR_FOURTEEN_BIT],        // [R16]
    st_ff.regs.hsEn[`PRCG_SERIAL_PORT_A_BIT],       // [R17]
    st_ff.regs.hsEn[`PRCG_SYNC_SERIAL_A_BIT],       // [R17]
    st_ff.regs.hsEn[`PRCG_ADVANCED_TMR_BIT],        // [R17]
    st_ff.regs.hsEn[`PRCG_CONVERTER_BIT],           // [R17]
    st_ff.regs.hsEn[`PRCG_SYSCFG_COMPARATOR_BIT],   // [R18]
    st_ff.regs.lsEn[`PRCG_POWER_UNIT_BIT],          // [R19]
    st_ff.regs.lsEn[`PRCG_TWO_WIRE_B_BIT],          // [R20]
    st_ff.regs.lsEn[`PRCG_TWO_WIRE_A_BIT],          // [R20]
    st_ff.regs.lsEn[`PRCG_SERIAL_PORT_B_BIT],       // [R20]
    st_ff.regs.lsEn[`PRCG_SYNC_SERIAL_B_BIT],       // [R20]
    st_ff.regs.lsEn[`PRCG_WINDOW_DOG_BIT],          // [R21]
    st_ff.regs.lsEn[`PRCG_TMR_THIRTEEN_BIT],        // [R21]
    st_ff.regs.lsEn[`PRCG_TMR_FIVE_BIT],            // [R21]
    st_ff.regs.lsEn[`PRCG_TMR_TWO_BIT]              // [R21]
  };

  // one glitch-free gate per peripheral clock, all fed by the bus clock
  generate
    for (genvar g = 0; g < `PRCG_NUM_GATES; g++) begin : gen_gate
      prcg_clk_gate u_gate (
        .clock    (clock),
        .rstN     (rstN),
        .enable   (gateEn[g]),
        .gatedClk (gatedVec[g])   // [R24]
      );
    end
  endgenerate

  // fan the gated vector out to the named clock ports
  assign {portFClk, portCClk, portBClk, portAClk,
          checksumClk, memTransferClk, flashCtrlClk, staticMemClk,
          debugSupportClk, tmrSixteenClk, tmrFifteenClk, tmrFourteenClk,
          serialPortAClk, syncSerialAClk, advancedTmrClk, converterClk,
          syscfgComparatorClk,
          powerUnitClk, twoWireBClk, twoWireAClk, serialPortBClk,
          syncSerialBClk, windowDogClk, tmrThirteenClk, tmrFiveClk,
          tmrTwoClk} = gatedVec;
endmodule

// file: prcg_top_sva.sv
// concurrent checks on the ports of the peripheral reset and clock gating top
`timescale 1ns/10ps
module prcg_top_sva (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 arst_n,
  // ahb-lite slave side
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [2:0]           hsize,
  input wire prcg_pkg::prcg_word_t hwdata,
  input wire logic                 hready,
  input wire prcg_pkg::prcg_word_t hrdata,
  // a sample of the reset outputs and one gated clock
  input wire logic                 tmrSixteenReset,
  input wire logic                 tmrFourteenReset,
  input wire logic                 serialPortAReset,
  input wire logic                 converterReset,
  input wire logic                 syscfgComparatorReset,
  input wire logic                 powerUnitReset,
  input wire logic                 twoWireAReset,
  input wire logic                 windowDogReset,
  input wire logic                 tmrTwoReset,
  input wire logic                 portAClk
);
  import prcg_pkg::*;
  logic wrHs_ff, wrLs_ff, rdHs_ff, rdLs_ff, wrWord_ff;
  logic take;
  logic [8:0] rstV;
  assign take = hsel && hready && htrans[1];
  assign rstV = {tmrSixteenReset, tmrFourteenReset, serialPortAReset, converterReset,
                 syscfgComparatorReset, powerUnitReset, twoWireAReset, windowDogReset, tmrTwoReset};
  // address-phase flags, so the data phase edge knows what it is finishing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {wrHs_ff, wrLs_ff, rdHs_ff, rdLs_ff, wrWord_ff} <= 5'h00;
    end else begin
      wrHs_ff  <= take && hwrite && hsize == 3'h2 && haddr[7:0] == 8'h0c;
      wrLs_ff  <= take && hwrite && hsize == 3'h2 && haddr[7:0] == 8'h10;
      rdHs_ff  <= take && !hwrite && haddr[7:0] == 8'h0c;
      rdLs_ff  <= take && !hwrite && haddr[7:0] == 8'h10;
      wrWord_ff <= take && hwrite && hsize == 3'h2; // narrow writes must leave outputs alone
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_hs_timer_rst: assert property (
    wrHs_ff |=> {tmrSixteenReset, tmrFourteenReset} == {$past(hwdata[18]), $past(hwdata[16])})
    else $error("timer reset outputs differ from written bits");
  a_hs_periph_rst: assert property (
    wrHs_ff |=> {serialPortAReset, converterReset} == {$past(hwdata[14]), $past(hwdata[9])})
    else $error("serial or converter reset differs from written bits");
  a_hs_cfg_rst: assert property (
    wrHs_ff |-> ##1 syscfgComparatorReset == $past(hwdata[0]))
    else $error("configuration reset differs from written bit");
  a_ls_power_rst: assert property (
    wrLs_ff |=> powerUnitReset == $past(hwdata[28]))
    else $error("power unit reset differs from written bit");
  a_ls_periph_rst: assert property (
    wrLs_ff |=> {twoWireAReset, windowDogReset, tmrTwoReset} ==
                {$past(hwdata[21]), $past(hwdata[11]), $past(hwdata[1])})
    else $error("low-speed reset outputs differ from written bits");
  a_rst_hold: assert property (
    !wrWord_ff |=> $stable(rstV))
    else $error("reset output moved without a write");
  a_hs_read_map: assert property (
    rdHs_ff |-> hrdata[31:19] == 13'h0000 && hrdata[18] == tmrSixteenReset &&
                hrdata[0] == syscfgComparatorReset)
    else $error("high-speed reset register read mismatch");
  a_ls_read_map: assert property (
    rdLs_ff |-> (hrdata & ~32'h1062_4912) == 32'h0000_0000 && hrdata[28] == powerUnitReset)
    else $error("low-speed reset register read mismatch");
  // a rise of the gated clock must coincide with a rise of the bus clock
  a_clean_rise: assert property (
    @(posedge portAClk) disable iff (!arst_n) !clock)
    else $error("gated clock rose inside a high phase");
endmodule

bind prcg_top prcg_top_sva u_sva (
  .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .tmrSixteenReset(tmrSixteenReset), .tmrFourteenReset(tmrFourteenReset),
  .serialPortAReset(serialPortAReset), .converterReset(converterReset),
  .syscfgComparatorReset(syscfgComparatorReset), .powerUnitReset(powerUnitReset),
  .twoWireAReset(twoWireAReset), .windowDogReset(windowDogReset),
  .tmrTwoReset(tmrTwoReset), .portAClk(portAClk)
);

// file: peripheral_reset_clock_gating_tb_top.sv
// self-checking bench for the peripheral reset and clock gating top
`timescale 1ns/10ps
`include "prcg_map.svh"
module peripheral_reset_clock_gating_tb_top;
  import prcg_pkg::*;
  logic             clock, arst_n, hsel, hwrite, sleepMode;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  prcg_word_t       hwdata, rdv;
  wire prcg_word_t  hrdata;
  wire logic        hready, hresp;
  // outputs gathered at their register positions; floating bits are masked off
  wire logic [31:0] hsR, lsR, syC, hsC, lsC;
  prcg_word_t       expReg [5];
  int               fail_count = 0;
  int               samples_checked = 0;
  localparam prcg_word_t MASKS [5] = '{`PRCG_MASK_HS_RST, `PRCG_MASK_LS_RST,
                                       `PRCG_MASK_SYS_EN, `PRCG_MASK_HS_EN, `PRCG_MASK_LS_EN};
  localparam prcg_ofs_t OFS [5] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  localparam prcg_word_t PATS [3] = '{32'hffff_ffff, 32'haaaa_aaaa, 32'h5555_5555};
  localparam prcg_word_t SLEEPV [3] = '{32'h0000_0000, 32'h0000_0010, 32'h0000_0004};

  prcg_top dut (
    .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .sleepMode(sleepMode),
    .tmrSixteenReset(hsR[18]), .tmrFifteenReset(hsR[17]), .tmrFourteenReset(hsR[16]),
    .serialPortAReset(hsR[14]), .syncSerialAReset(hsR[12]), .advancedTmrReset(hsR[11]),
    .converterReset(hsR[9]), .syscfgComparatorReset(hsR[0]), .powerUnitReset(lsR[28]),
    .twoWireBReset(lsR[22]), .twoWireAReset(lsR[21]), .serialPortBReset(lsR[17]),
    .syncSerialBReset(lsR[14]), .windowDogReset(lsR[11]), .tmrThirteenReset(lsR[8]),
    .tmrFiveReset(lsR[4]), .tmrTwoReset(lsR[1]), .portFClk(syC[22]), .portCClk(syC[19]),
    .portBClk(syC[18]), .portAClk(syC[17]), .checksumClk(syC[6]), .memTransferClk(syC[0]),
    .flashCtrlClk(syC[4]), .staticMemClk(syC[2]), .debugSupportClk(hsC[22]),
    .tmrSixteenClk(hsC[18]), .tmrFifteenClk(hsC[17]), .tmrFourteenClk(hsC[16]),
    .serialPortAClk(hsC[14]), .syncSerialAClk(hsC[12]), .advancedTmrClk(hsC[11]),
    .converterClk(hsC[9]), .syscfgComparatorClk(hsC[0]), .powerUnitClk(lsC[28]),
    .twoWireBClk(lsC[22]), .twoWireAClk(lsC[21]), .serialPortBClk(lsC[17]),
    .syncSerialBClk(lsC[14]), .windowDogClk(lsC[11]), .tmrThirteenClk(lsC[8]),
    .tmrFiveClk(lsC[4]), .tmrTwoClk(lsC[1])
  );

  // free-running bus clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string what, input prcg_word_t exp, input prcg_word_t got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single ahb-lite transfer; entered and left just after a rising edge
  task automatic bus(input prcg_ofs_t ofs, input logic wr, input logic [2:0] sz,
                     input prcg_word_t d, output prcg_word_t q);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, ofs};
    htrans <= `PRCG_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask

  // write a mapped register and follow it in the model; narrow writes are dropped
  task automatic wr(input int i, input prcg_word_t d, input logic [2:0] sz);
    prcg_word_t q;
    bus(OFS[i], 1'b1, sz, d, q);
    if (sz == 3'h2) expReg[i] = d & MASKS[i];
  endtask

  // read back every register, then look at resets in the high phase and gated clocks in both clock phases
  task automatic chk_all();
    prcg_word_t q;
    for (int i = 0; i < 5; i++) begin
      bus(OFS[i], 1'b0, 3'h2, 32'h0000_0000, q);
      chk("register readback", expReg[i], q);
    end
    chk("bus ready and response", 32'h0000_0002, {30'h0000_0000, hready, hresp});
    chk("high-speed resets", expReg[0], hsR & MASKS[0]);
    chk("low-speed resets", expReg[1], lsR & MASKS[1]);
    #2;
    chk("system clocks", expReg[2] | (sleepMode ? 32'h0000_0000 : 32'h0000_0014), syC & MASKS[2]);
    chk("high-speed clocks", expReg[3], hsC & MASKS[3]);
    chk("low-speed clocks", expReg[4], lsC & MASKS[4]);
    #5;
    chk("clocks in low phase", 32'h0000_0000,
        (syC & MASKS[2]) | (hsC & MASKS[3]) | (lsC & MASKS[4]));
    @(posedge clock);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end

  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    sleepMode = 1'b0;
    for (int r = 0; r < 2; r++) begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      expReg = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0014, 32'h0000_0000, 32'h0000_0000};
      chk_all();
      // unmapped space reads zero and swallows writes
      bus(8'h20, 1'b1, 3'h2, 32'hffff_ffff, rdv);
      bus(8'h20, 1'b0, 3'h2, 32'h0000_0000, rdv);
      chk("unmapped read", 32'h0000_0000, rdv);
      foreach (PATS[p]) begin
        for (int i = 0; i < 5; i++) wr(i, PATS[p], 3'h2);
        chk_all();
      end
      // byte and halfword writes must leave everything untouched
      for (int i = 0; i < 5; i++) wr(i, 32'hffff_ffff, 3'(i % 2));
      chk_all();
      // the two sleep bits only matter while the core sleeps
      sleepMode <= 1'b1;
      foreach (SLEEPV[s]) begin
        wr(2, SLEEPV[s], 3'h2);
        chk_all();
      end
      sleepMode <= 1'b0;
      chk_all();
      // second pass starts from a mid-run reset with everything set
      for (int i = 0; i < 5; i++) wr(i, 32'hffff_ffff, 3'h2);
      arst_n <= 1'b0;
    end
    wrap_up();
  end
endmodule
